// ---- inc/epw_cfg.svh ----
// Address map, bit positions, reset values and timing of the EEPROM write controller
`ifndef EPW_CFG_SVH
`define EPW_CFG_SVH

// ==========================================================================
// Data-space register indexes (byte address on APB is four times these)
`define EPW_WIN_FIRST      8'h00
`define EPW_WIN_LAST       8'h3F
`define EPW_OFS_BANK       8'hE8
`define EPW_OFS_DDC_CTL    8'hE9
`define EPW_OFS_CTL        8'hEA

// ==========================================================================
// Control register bit positions
`define EPW_BIT_UNLOCK     0
`define EPW_BIT_BUSY       1
`define EPW_BIT_ROW_EN     2
`define EPW_BIT_START      3
`define EPW_BIT_TEST_LO    4
`define EPW_BIT_TEST_HI    5
`define EPW_BIT_STANDBY    6

// ==========================================================================
// Bank select codes
`define EPW_BANK_EE0       8'h01
`define EPW_BANK_EE1       8'h02
`define EPW_BANK_EE2       8'h03
`define EPW_BANK_RAM2      8'h04
`define EPW_BANK_RAM3      8'h08
`define EPW_BANK_DDC0      8'h10
`define EPW_BANK_DDC1      8'h20
`define EPW_BANK_EE3       8'h81
`define EPW_BANK_EE4       8'h82
`define EPW_BANK_EE5       8'h83

// ==========================================================================
// Reset values
`define EPW_CTL_RESET      8'h00
`define EPW_BANK_RESET     8'h00
`define EPW_ERASED         8'hFF

// ==========================================================================
// Timing
`define EPW_CLK_PERIOD_NS  4
`define EPW_WRITE_TIME_NS  5000000
`define EPW_WRITE_CYCLES   (`EPW_WRITE_TIME_NS / `EPW_CLK_PERIOD_NS)

`endif

// ---- inc/epw_pkg.sv ----
// Types shared by the EEPROM write controller and its bench
`default_nettype none

package epw_pkg;

   // ========================================================================
   // Target of the low data-space window
   typedef enum logic [1:0] {
      EPW_TGT_NONE,
      EPW_TGT_EE,
      EPW_TGT_RAM,
      EPW_TGT_DDC
   } epw_tgt_t;

   typedef struct packed {
      epw_tgt_t   tgt;
      logic [2:0] page;
   } epw_sel_t;

   // ========================================================================
   // APB carriers
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } epw_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } epw_apb_rsp_t;

   // ========================================================================
   // One write controller (standard or DDC)
   typedef struct packed {
      logic            standby;
      logic            row_en;
      logic            start;
      logic            busy;
      logic            unlock;
      logic            row_valid;
      logic [5:0]      row;
      logic [7:0][7:0] lat_data;
      logic [7:0]      lat_loaded;
      logic [8:0]      addr;
      logic [7:0]      data;
      logic [23:0]     timer;
   } epw_ctl_t;

   typedef struct packed {
      epw_ctl_t ctl;
      logic     err;
   } epw_wr_res_t;

   // ========================================================================
   // Whole state of the controller
   typedef struct packed {
      epw_apb_rsp_t      rsp;
      logic [7:0]        bank;
      epw_ctl_t          ee;
      epw_ctl_t          ddc;
      logic [511:0][7:0] ee_mem;
      logic [127:0][7:0] ddc_mem;
      logic [127:0][7:0] ram_mem;
   } epw_state_t;

endpackage : epw_pkg

`default_nettype wire

// ---- rtl/epw_ctrl.sv ----
// EEPROM bank window and byte/row write controller behind an APB slave
//
// Overview of operation
// - Data-space 00h-3Fh shows a bank-selected 64-byte page; six EEPROM pages.
// - Bank codes pick EEPROM pages 0-5, RAM pages 2-3, DDC pages 0-1.
// - EEPROM reads behave like ordinary locations, same access time.
// - Each EEPROM write lasts the programming time; array inaccessible meanwhile.
// - Two write modes: single byte, or row of up to eight bytes.
// - Standby bit is write-only; set, the EEPROM is disabled and reads meaningless.
// - Start bit is set by software only, programs the row, cleared by hardware.
// - Fewer than eight bytes may be loaded; unloaded bytes are undefined.
// - Row mode without start: writes fill row latches; A2-A0 select the byte.
// - Row mode bit write-only, cleared after row programming, software may clear.
// - Busy flag set by a write; accesses during busy abort, write completes.
// - Writes need the unlock bit; without it nothing changes, busy stays clear.
// - While busy, control writes are ignored; only busy reads back.
// - First write after row mode enable latches the row until end or disable.
// - Setting row mode enable clears all eight row latches.
// - Start programs only the bytes whose latches were written.
// - Start accepted only with unlock and row mode enable set.
// - A second identical control register governs the DDC EEPROM.
// - Bank select register is write-only; its content after reset is unspecified.
`include "epw_cfg.svh"
`default_nettype none

module epw_ctrl #(
   parameter int unsigned WRITE_CYCLES = `EPW_WRITE_CYCLES
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   input  wire epw_pkg::epw_apb_req_t apb_req,
   output var  epw_pkg::epw_apb_rsp_t apb_rsp,
   output logic                       ee_busy,
   output logic                       ddc_busy,
   output logic                       ee_standby,
   output logic                       ddc_standby
);
   import epw_pkg::*;

   localparam logic [23:0] WRITE_LOAD = WRITE_CYCLES[23:0];
   // Timer is 24 bits: WRITE_CYCLES must stay below 2**24

   // Each array has its own timer: one may program while the other is read

   epw_state_t state;
   epw_state_t next_state;

   // =======================================================================
   // Functions

   // Codes outside the table select nothing, so the window is refused.
   // RAM pages 2 and 3 map onto local pages 0 and 1.
   function automatic epw_sel_t bank_decode(input logic [7:0] code);
      epw_sel_t s;

      s.tgt  = EPW_TGT_NONE;
      s.page = 3'd0;
      unique case (code)
         `EPW_BANK_EE0:  s = '{EPW_TGT_EE, 3'd0};
         `EPW_BANK_EE1:  s = '{EPW_TGT_EE, 3'd1};
         `EPW_BANK_EE2:  s = '{EPW_TGT_EE, 3'd2};
         `EPW_BANK_EE3:  s = '{EPW_TGT_EE, 3'd3};
         `EPW_BANK_EE4:  s = '{EPW_TGT_EE, 3'd4};
         `EPW_BANK_EE5:  s = '{EPW_TGT_EE, 3'd5};
         `EPW_BANK_RAM2: s = '{EPW_TGT_RAM, 3'd0};
         `EPW_BANK_RAM3: s = '{EPW_TGT_RAM, 3'd1};
         `EPW_BANK_DDC0: s = '{EPW_TGT_DDC, 3'd0};
         `EPW_BANK_DDC1: s = '{EPW_TGT_DDC, 3'd1};
         default:        s = '{EPW_TGT_NONE, 3'd0};
      endcase
      return s;
   endfunction : bank_decode

   // Control register write; ignored entirely while a write is running.
   // Start needs row mode already on, else it would program latches
   // cleared in the same cycle.
   function automatic epw_ctl_t ctl_write(input epw_ctl_t c, input logic [7:0] wd);
      epw_ctl_t n;

      n = c;
      if (!c.busy) begin
         n.standby = wd[`EPW_BIT_STANDBY];
         n.unlock  = wd[`EPW_BIT_UNLOCK];
         n.row_en  = wd[`EPW_BIT_ROW_EN];
         // Only a 0 to 1 step of row mode clears the latches
         if (wd[`EPW_BIT_ROW_EN] && !c.row_en) begin
            n.lat_data   = '0;
            n.lat_loaded = '0;
            n.row_valid  = 1'b0;
         end
         if (!wd[`EPW_BIT_ROW_EN]) begin
            // Leaving row mode drops the latched row and programs nothing
            n.row_valid  = 1'b0;
            n.lat_loaded = '0;
         end
         if (wd[`EPW_BIT_START] && wd[`EPW_BIT_UNLOCK] && wd[`EPW_BIT_ROW_EN]
             && c.row_en && !c.standby) begin
            n.start = 1'b1;
            n.busy  = 1'b1;
            n.timer = WRITE_LOAD;
         end
      end
      return n;
   endfunction : ctl_write

   // Data write into a page owned by one controller.
   // Locked or standby: no row latch, no byte write, no busy.
   // A foreign row is refused once a row is latched.
   function automatic epw_wr_res_t ctl_data_write(input epw_ctl_t c,
                                                  input logic [8:0] a,
                                                  input logic [7:0] wd);
      epw_wr_res_t r;
      r.ctl = c;
      r.err = 1'b0;
      if (c.busy) begin
         r.err = 1'b1;
      end else if (c.standby || !c.unlock) begin
         r.err = c.standby;
      end else if (c.row_en) begin
         if (!c.row_valid) begin
            r.ctl.row_valid = 1'b1;
            r.ctl.row       = a[8:3];
         end
         if (c.row_valid && (c.row != a[8:3])) begin
            r.err = 1'b1;
         end else begin
            r.ctl.lat_data[a[2:0]]   = wd;
            r.ctl.lat_loaded[a[2:0]] = 1'b1;
         end
      end else begin
         r.ctl.addr  = a;
         r.ctl.data  = wd;
         r.ctl.busy  = 1'b1;
         r.ctl.timer = WRITE_LOAD;
      end
      return r;
   endfunction : ctl_data_write

   // End of programming: all hardware-cleared bits drop together.
   // Unloaded row bytes keep their old value, one reading of undefined.
   function automatic epw_ctl_t ctl_finish(input epw_ctl_t c);
      epw_ctl_t n;

      n = c;
      n.busy = 1'b0;
      if (c.start) begin
         n.start      = 1'b0;
         n.row_en     = 1'b0;
         n.row_valid  = 1'b0;
         n.lat_loaded = '0;
      end
      return n;
   endfunction : ctl_finish

   function automatic logic [7:0] ctl_read(input epw_ctl_t c);
      logic [7:0] v;
      v = 8'h00;
      v[`EPW_BIT_BUSY] = c.busy;
      // Start drops with busy, so it reads back as zero
      v[`EPW_BIT_START] = c.start & ~c.busy;
      return v;
   endfunction : ctl_read

   // Last programming cycle: array, busy, start and
   // row mode all change on this edge
   function automatic logic ctl_due(input epw_ctl_t c);
      logic d;

      d = c.busy && (c.timer <= 24'd1);
      return d;
   endfunction : ctl_due

   // Window write refusal, known a cycle before the write lands;
   // it mirrors ctl_data_write so response and effect agree
   function automatic logic win_wr_err(input epw_ctl_t c, input logic [5:0] row);
      logic e;

      e = c.busy || c.standby;
      if (c.unlock && c.row_en && c.row_valid && (c.row != row)) begin
         e = 1'b1;
      end
      return e;
   endfunction : win_wr_err

   // A window read while busy is aborted, not delayed;
   // the running write is left to finish
   function automatic logic rd_err(input epw_ctl_t c);
      logic e;

      e = c.busy;
      return e;
   endfunction : rd_err

   // =======================================================================
   // Next-state logic
   // One packed state; ce low freezes it all, pready too, so a
   // transfer just stretches

   logic       access;
   logic       setup;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic       mapped;
   epw_sel_t   sel;
   logic [8:0] ee_a;
   logic [6:0] sm_a;
   epw_wr_res_t wres;

   always_comb begin
      next_state = state;
      idx    = apb_req.paddr[9:2];
      wbyte  = apb_req.pwdata[7:0];
      sel    = bank_decode(state.bank);
      ee_a   = {sel.page, idx[5:0]};
      sm_a   = {sel.page[0], idx[5:0]};
      wres   = '0;

      // Three register indexes and the window answer; the rest is refused
      mapped = (apb_req.paddr[11:10] == 2'b00)
               && ((idx <= `EPW_WIN_LAST) || (idx == `EPW_OFS_BANK)
                   || (idx == `EPW_OFS_DDC_CTL) || (idx == `EPW_OFS_CTL));
      access = apb_req.psel && apb_req.penable && state.rsp.pready;
      setup  = apb_req.psel && apb_req.penable && !state.rsp.pready;


      // ==================================================================
      // Programming timers; the array changes only on the last cycle,
      // so an aborted access never sees a half-written row
      if (state.ee.busy) begin
         // Busy, start, row mode and the array share the last edge
         next_state.ee.timer = state.ee.timer - 24'd1;
         if (ctl_due(state.ee)) begin
            if (state.ee.start) begin
               for (int i = 0; i < 8; i++) begin
                  if (state.ee.lat_loaded[i]) begin
                     next_state.ee_mem[{state.ee.row, i[2:0]}] = state.ee.lat_data[i];
                  end
               end
            end else begin
               next_state.ee_mem[state.ee.addr] = state.ee.data;
            end
            next_state.ee = ctl_finish(state.ee);
         end
      end

      // The DDC array holds 128 bytes: only the low row bits address it
      if (state.ddc.busy) begin
         next_state.ddc.timer = state.ddc.timer - 24'd1;
         if (ctl_due(state.ddc)) begin
            if (state.ddc.start) begin
               for (int i = 0; i < 8; i++) begin
                  if (state.ddc.lat_loaded[i]) begin
                     next_state.ddc_mem[{state.ddc.row[3:0], i[2:0]}] =
                        state.ddc.lat_data[i];
                  end
               end
            end else begin
               next_state.ddc_mem[state.ddc.addr[6:0]] = state.ddc.data;
            end
            next_state.ddc = ctl_finish(state.ddc);
         end
      end


      // ==================================================================
      // APB answer, prepared in the first access cycle: exactly one wait
      // state, and prdata always comes from a register
      next_state.rsp.pready  = setup;
      next_state.rsp.prdata  = '0;
      next_state.rsp.pslverr = 1'b0;
      if (setup) begin
         next_state.rsp.pslverr = !mapped;
         if (!apb_req.pwrite && idx <= `EPW_WIN_LAST) begin
            unique case (sel.tgt)
               EPW_TGT_EE: begin
                  // Standby reads give zero rather than stale data
                  if (rd_err(state.ee)) begin
                     next_state.rsp.pslverr = 1'b1;
                  end else if (!state.ee.standby) begin
                     next_state.rsp.prdata[7:0] = state.ee_mem[ee_a];
                  end
               end
               EPW_TGT_DDC: begin
                  if (rd_err(state.ddc)) begin
                     next_state.rsp.pslverr = 1'b1;
                  end else if (!state.ddc.standby) begin
                     next_state.rsp.prdata[7:0] = state.ddc_mem[sm_a];
                  end
               end
               // RAM has no busy state and is never refused
               EPW_TGT_RAM: next_state.rsp.prdata[7:0] = state.ram_mem[sm_a];
               EPW_TGT_NONE: next_state.rsp.pslverr = 1'b1;
            endcase
         end else if (!apb_req.pwrite && idx == `EPW_OFS_CTL) begin
            next_state.rsp.prdata[7:0] = ctl_read(state.ee);
         end else if (!apb_req.pwrite && idx == `EPW_OFS_DDC_CTL) begin
            next_state.rsp.prdata[7:0] = ctl_read(state.ddc);
         end else if (apb_req.pwrite && idx <= `EPW_WIN_LAST) begin
            // Write errors are decided here, the write itself lands a cycle later
            unique case (sel.tgt)
               EPW_TGT_EE: begin
                  next_state.rsp.pslverr = win_wr_err(state.ee, ee_a[8:3]);
               end
               EPW_TGT_DDC: begin
                  next_state.rsp.pslverr = win_wr_err(state.ddc, {2'b00, sm_a[6:3]});
               end
               EPW_TGT_RAM:  next_state.rsp.pslverr = 1'b0;
               EPW_TGT_NONE: next_state.rsp.pslverr = 1'b1;
            endcase
         end
      end


      // ==================================================================
      // APB write lands at the completing edge; only byte lane 0 counts,
      // so pstrb[0] low makes the transfer a no-op
      if (access && apb_req.pwrite && apb_req.pstrb[0] && mapped) begin
         if (idx <= `EPW_WIN_LAST) begin
            unique case (sel.tgt)
               EPW_TGT_EE: begin
                  wres = ctl_data_write(next_state.ee, ee_a, wbyte);
                  next_state.ee = wres.ctl;
               end
               EPW_TGT_DDC: begin
                  wres = ctl_data_write(next_state.ddc, {2'b00, sm_a}, wbyte);
                  next_state.ddc = wres.ctl;
               end
               EPW_TGT_RAM:  next_state.ram_mem[sm_a] = wbyte;
               EPW_TGT_NONE: next_state.bank = state.bank;
            endcase
         end else if (idx == `EPW_OFS_BANK) begin
            // Bank writes are taken even while an array programs
            next_state.bank = wbyte;
         end else if (idx == `EPW_OFS_CTL) begin
            next_state.ee = ctl_write(next_state.ee, wbyte);
         end else begin
            next_state.ddc = ctl_write(next_state.ddc, wbyte);
         end
      end
   end

   // =======================================================================
   // State register
   // Arrays come up erased, RAM cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= '0;
         // Bank value after reset is unspecified; zero selects nothing
         state.bank    <= `EPW_BANK_RESET;
         state.ee_mem  <= {512{`EPW_ERASED}};
         state.ddc_mem <= {128{`EPW_ERASED}};
      end else if (ce) begin
         state <= next_state;
      end
   end


   // Every port comes straight from the state register
   assign apb_rsp     = state.rsp;
   assign ee_busy     = state.ee.busy;
   assign ddc_busy    = state.ddc.busy;
   assign ee_standby  = state.ee.standby;
   assign ddc_standby = state.ddc.standby;

endmodule : epw_ctrl

`default_nettype wire

// ---- tb/epw_ctrl_props.sv ----
// Port-level checks of the EEPROM write controller
`default_nettype none

module epw_ctrl_props
   import epw_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = 20
) (
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         ce,
   input wire epw_apb_req_t apb_req,
   input wire epw_apb_rsp_t apb_rsp,
   input wire logic         ee_busy,
   input wire logic         ddc_busy,
   input wire logic         ee_standby,
   input wire logic         ddc_standby
);
   // ==========================================================================
   // Helper logic
   logic [23:0] ee_cnt;
   logic [23:0] ddc_cnt;
   logic        fin;
   logic        ctl_acc;
   assign fin = apb_rsp.pready & apb_req.psel & apb_req.penable;
   assign ctl_acc = fin & (apb_req.paddr == 12'h3A8);

   // Busy run lengths; held while ce is low since the design freezes too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ee_cnt  <= 24'h0;
         ddc_cnt <= 24'h0;
      end else if (ce) begin
         ee_cnt  <= ee_busy ? ee_cnt + 24'h1 : 24'h0;
         ddc_cnt <= ddc_busy ? ddc_cnt + 24'h1 : 24'h0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================================
   // Assertions
   sequence s_setup;
      apb_req.psel && !apb_req.penable && ce;
   endsequence
   sequence s_access;
      apb_req.psel && apb_req.penable && !apb_rsp.pready && ce;
   endsequence

   a_one_wait_state: assert property (s_setup ##1 s_access |=> apb_rsp.pready)
      else $error("pready not one wait state after access");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (fin && apb_req.paddr[9:2] inside {[8'h40:8'hE7]}
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped index not refused");
   a_bank_write_only: assert property (fin && !apb_req.pwrite && apb_req.paddr == 12'h3A0
      |-> apb_rsp.prdata == 32'h0)
      else $error("bank select read not zero");
   a_busy_from_write: assert property ($rose(ee_busy)
      |-> $past(fin && apb_req.pwrite && !apb_rsp.pslverr))
      else $error("busy rose without an accepted write");
   a_busy_length: assert property ($fell(ee_busy) |-> {8'h0, ee_cnt} == WRITE_CYCLES)
      else $error("busy length wrong");
   a_ddc_busy_length: assert property ($fell(ddc_busy)
      |-> {8'h0, ddc_cnt} == WRITE_CYCLES)
      else $error("ddc busy length wrong");
   a_ctl_locked: assert property (ctl_acc && apb_req.pwrite && ee_busy
      |=> $stable(ee_standby))
      else $error("control changed while busy");
   a_standby_write: assert property (ctl_acc && apb_req.pwrite && apb_req.pstrb[0]
      && !ee_busy |=> ee_standby == $past(apb_req.pwdata[6]))
      else $error("standby not taken from write");
   a_ddc_standby_write: assert property (fin && apb_req.paddr == 12'h3A4 && apb_req.pwrite
      && apb_req.pstrb[0] && !ddc_busy |=> ddc_standby == $past(apb_req.pwdata[6]))
      else $error("ddc standby not taken from write");
   a_ctl_read_busy: assert property (ctl_acc && !apb_req.pwrite && $stable(ee_busy)
      |-> apb_rsp.prdata[31:8] == 24'h0 && apb_rsp.prdata[1] == ee_busy)
      else $error("control read busy bit wrong");
endmodule : epw_ctrl_props

`default_nettype wire

// ---- tb/tb_epw_ctrl.sv ----
// Self-checking bench of the EEPROM write controller over APB
`include "epw_cfg.svh"
`default_nettype none

module tb_epw_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import epw_pkg::*;

   localparam int unsigned WCYC = 20;
   logic         pclk;
   logic         presetn;
   epw_apb_req_t apb_req;
   epw_apb_rsp_t apb_rsp;
   logic         ee_busy;
   logic         ddc_busy;
   logic         ee_standby;
   logic         ddc_standby;
   int           miscompares = 0;
   int           checks = 0;
   int           cycles = 0;
   logic [7:0]   rd;
   logic         err;
   logic [7:0]   codes [10] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83,
                                8'h04, 8'h08, 8'h10, 8'h20};

   epw_ctrl #(
      .WRITE_CYCLES (WCYC)
   ) i_epw_ctrl (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (1'b1),
      .apb_req     (apb_req),
      .apb_rsp     (apb_rsp),
      .ee_busy     (ee_busy),
      .ddc_busy    (ddc_busy),
      .ee_standby  (ee_standby),
      .ddc_standby (ddc_standby)
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ==========================================================================
   // Tasks
   task automatic test_done;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= w;
      apb_req.paddr   <= {2'b00, idx, 2'b00};
      apb_req.pwdata  <= {24'h0, wd};
      apb_req.pstrb   <= 4'hF;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rd  = apb_rsp.prdata[7:0];
      err = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd, input logic e);
      apb(1'b1, idx, wd);
      chk_bit(err, e);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic e);
      apb(1'b0, idx, 8'h00);
      chk_byte(rd, exp);
      chk_bit(err, e);
   endtask : rdc

   // Busy updates land at the completing edge, so look half a cycle later
   task automatic busy_chk(input logic e_ee, input logic e_ddc);
      @(negedge pclk);
      chk_bit(ee_busy, e_ee);
      chk_bit(ddc_busy, e_ddc);
   endtask : busy_chk

   task automatic wait_idle;
      int n;
      n = 0;
      @(negedge pclk);
      while ((ee_busy | ddc_busy) !== 1'b0 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      chk_bit(ee_busy | ddc_busy, 1'b0);
   endtask : wait_idle

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ==========================================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      apb_req = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`EPW_OFS_CTL, 8'h00, 1'b0);
      rdc(`EPW_OFS_DDC_CTL, 8'h00, 1'b0);
      rdc(`EPW_OFS_BANK, 8'h00, 1'b0);
      rdc(8'h50, 8'h00, 1'b1);
      rdc(8'h00, 8'h00, 1'b1);
      wr(`EPW_OFS_BANK, 8'h01, 1'b0);
      wr(8'h03, 8'h5A, 1'b0);
      busy_chk(1'b0, 1'b0);
      rdc(8'h03, 8'hFF, 1'b0);
      wr(`EPW_OFS_CTL, 8'h01, 1'b0);
      wr(`EPW_OFS_DDC_CTL, 8'h01, 1'b0);
      // Distinct byte per page shows any aliasing between codes
      for (int i = 0; i < 10; i++) begin
         wr(`EPW_OFS_BANK, codes[i], 1'b0);
         wr(8'h05, codes[i], 1'b0);
         wait_idle();
      end
      for (int i = 0; i < 10; i++) begin
         wr(`EPW_OFS_BANK, codes[i], 1'b0);
         rdc(8'h05, codes[i], 1'b0);
      end
      wr(`EPW_OFS_BANK, 8'h01, 1'b0);
      wr(8'h03, 8'hA5, 1'b0);
      busy_chk(1'b1, 1'b0);
      rdc(8'h03, 8'h00, 1'b1);
      wr(`EPW_OFS_CTL, 8'h40, 1'b0);
      rdc(`EPW_OFS_CTL, 8'h02, 1'b0);
      chk_bit(ee_standby, 1'b0);
      wait_idle();
      rdc(8'h03, 8'hA5, 1'b0);
      wr(`EPW_OFS_BANK, 8'h02, 1'b0);
      wr(`EPW_OFS_CTL, 8'h05, 1'b0);
      wr(8'h18, 8'h11, 1'b0);
      wr(8'h1A, 8'h22, 1'b0);
      wr(8'h1B, 8'h33, 1'b0);
      wr(8'h20, 8'h44, 1'b1);
      wr(`EPW_OFS_CTL, 8'h0D, 1'b0);
      busy_chk(1'b1, 1'b0);
      wait_idle();
      rdc(8'h18, 8'h11, 1'b0);
      rdc(8'h1A, 8'h22, 1'b0);
      rdc(8'h1B, 8'h33, 1'b0);
      rdc(8'h19, 8'hFF, 1'b0);
      rdc(8'h20, 8'hFF, 1'b0);
      rdc(`EPW_OFS_CTL, 8'h00, 1'b0);
      wr(8'h21, 8'h55, 1'b0);
      busy_chk(1'b1, 1'b0);
      wait_idle();
      rdc(8'h21, 8'h55, 1'b0);
      wr(`EPW_OFS_CTL, 8'h09, 1'b0);
      busy_chk(1'b0, 1'b0);
      rdc(`EPW_OFS_CTL, 8'h00, 1'b0);
      wr(`EPW_OFS_CTL, 8'h05, 1'b0);
      wr(8'h08, 8'hAA, 1'b0);
      wr(`EPW_OFS_CTL, 8'h01, 1'b0);
      busy_chk(1'b0, 1'b0);
      rdc(8'h08, 8'hFF, 1'b0);
      wr(`EPW_OFS_CTL, 8'h05, 1'b0);
      wr(8'h09, 8'hBB, 1'b0);
      wr(`EPW_OFS_CTL, 8'h0D, 1'b0);
      wait_idle();
      rdc(8'h08, 8'hFF, 1'b0);
      rdc(8'h09, 8'hBB, 1'b0);
      wr(`EPW_OFS_BANK, 8'h10, 1'b0);
      wr(`EPW_OFS_DDC_CTL, 8'h40, 1'b0);
      @(negedge pclk);
      chk_bit(ddc_standby, 1'b1);
      apb(1'b0, 8'h05, 8'h00);
      chk_byte(rd, 8'h00);
      wr(8'h05, 8'h99, 1'b1);
      wr(`EPW_OFS_DDC_CTL, 8'h01, 1'b0);
      rdc(8'h05, 8'h10, 1'b0);
      test_done();
   end
endmodule : tb_epw_ctrl

bind epw_ctrl epw_ctrl_props #(
   .WRITE_CYCLES (WRITE_CYCLES)
) i_epw_ctrl_props (
   .pclk        (pclk),
   .presetn     (presetn),
   .ce          (ce),
   .apb_req     (apb_req),
   .apb_rsp     (apb_rsp),
   .ee_busy     (ee_busy),
   .ddc_busy    (ddc_busy),
   .ee_standby  (ee_standby),
   .ddc_standby (ddc_standby)
);

`default_nettype wire
